// *** design/dacsd_pkg.sv ***
package dacsd_pkg;

    // Frame geometry
    localparam int CMD_BITS = 8;
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int NUM_CH = 8;
    localparam int BYTE_BITS = 8;
    localparam int LEAD_ZEROS = 4;
    localparam int CMD_LAST_EDGE = CMD_BITS - 1;
    localparam int WORD_LAST_EDGE = CMD_BITS + WORD_BITS - 1;
    localparam int FRAME_SAT = CMD_BITS + WORD_BITS;

    // Command byte upper nibble that routes the next word to the DAC decoder
    localparam logic [3:0] SELECT_NIBBLE = 4'h1;

    // Field positions inside the 16-bit word
    localparam int CTRL_MSB = 15;
    localparam int CTRL_LSB = 12;
    localparam int PRESET_BIT_A = 11;
    localparam int PRESET_BIT_B = 9;
    localparam int MASK_LSB = 4;
    localparam int PMODE_MSB = 3;
    localparam int PMODE_LSB = 1;

    // Control codes
    localparam logic [3:0] CTRL_NOP = 4'h0;
    localparam logic [3:0] CTRL_RESET = 4'h1;
    localparam logic [3:0] CTRL_LOAD_FIRST = 4'h2;
    localparam logic [3:0] CTRL_LOAD_LAST = 4'h9;
    localparam logic [3:0] CTRL_WT_LOW = 4'ha;
    localparam logic [3:0] CTRL_WT_HIGH = 4'hb;
    localparam logic [3:0] CTRL_WT_ALL = 4'hc;
    localparam logic [3:0] CTRL_IN_ALL = 4'hd;
    localparam logic [3:0] CTRL_XFER = 4'he;
    localparam logic [3:0] CTRL_POWER = 4'hf;

    // Register fill values
    localparam logic [11:0] CLEAR_VAL = 12'h000;
    localparam logic [11:0] PRESET_VAL = 12'hfff;

    // Power mode field codes
    localparam logic [2:0] PM_UP = 3'h1;
    localparam logic [2:0] PM_HIZ = 3'h2;
    localparam logic [2:0] PM_GND_1K = 3'h4;
    localparam logic [2:0] PM_GND_100K = 3'h0;
    localparam logic [2:0] PM_REF_100K = 3'h7;

    // Output buffer state of one channel
    typedef enum logic [2:0] {
        PWR_ON = 3'h0,
        PWR_HIZ = 3'h1,
        PWR_GND_100K = 3'h2,
        PWR_GND_1K = 3'h3,
        PWR_REF_100K = 3'h6
    } dacsd_pwr_type;

    localparam dacsd_pwr_type RESET_PWR = PWR_GND_100K;

    // Link frame phase, Gray along command, word, rest
    typedef enum logic [1:0] {
        PH_CMD = 2'h0,
        PH_WORD = 2'h1,
        PH_REST = 2'h3
    } dacsd_phase_type;

endpackage : dacsd_pkg

// *** design/dacsd_link.sv ***
`timescale 1ns/1ps

module dacsd_link
    import dacsd_pkg::*;
(
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_q,
    output logic dout_oe_q,
    // Global reset, applied asynchronously here
    input wire logic srst,
    // Decoded word towards the core
    output logic [WORD_BITS-1:0] word_q,
    output logic word_tgl_q,
    // Result entry from the core
    input wire logic [WORD_BITS-1:0] res_word,
    input wire logic res_tgl,
    output logic ack_tgl_q
);

    // Whole link state
    typedef struct packed {
        dacsd_phase_type phase;    // Frame phase
        logic [4:0] cnt;           // Edges seen this frame
        logic [7:0] cmd;           // Command byte shifter
        logic [15:0] shift;        // Word shifter
        logic [15:0] word;         // Last complete word
        logic word_tgl;            // Flips per complete word
        logic res_s1;              // Result toggle sync, first stage
        logic res_s2;              // Result toggle sync, second stage
        logic [4:0] rd_pos;        // Next result bit to send
        logic ack_tgl;             // Flips per consumed entry
        logic dout;                // Data-out level
        logic dout_oe;             // Data-out drive
    } dacsd_link_type;

    dacsd_link_type q, d;

    // Round a read position up to the next byte boundary
    function automatic logic [4:0] round_byte(input logic [4:0] p);
        logic [4:0] s;
        s = p + 5'h07;
        return {s[4:3], 3'h0};
    endfunction : round_byte

    logic [7:0] cmd_next;
    logic [15:0] shift_next;
    logic [4:0] eff_pos;
    logic avail;

    // Next-state logic, one falling edge per step
    always_comb begin
        d = q;
        cmd_next = {q.cmd[6:0], din};
        shift_next = {q.shift[14:0], din};
        d.res_s1 = res_tgl;
        d.res_s2 = q.res_s1;
        d.dout_oe = 1'b1;
        if (q.cnt != 5'(FRAME_SAT)) begin
            d.cnt = q.cnt + 5'h01;
        end
        unique case (q.phase)
            PH_CMD: begin
                d.cmd = cmd_next;
                // Short command byte never leaves this phase
                if (q.cnt == 5'(CMD_LAST_EDGE)) begin
                    d.phase = (cmd_next[7:4] == SELECT_NIBBLE) ? PH_WORD : PH_REST;
                end
            end
            PH_WORD: begin
                d.shift = shift_next;
                // Commit only on the last bit; an early cs rise drops it
                if (q.cnt == 5'(WORD_LAST_EDGE)) begin
                    d.word = shift_next;
                    d.word_tgl = ~q.word_tgl;
                    d.phase = PH_REST;
                end
            end
            PH_REST: begin
                d.phase = PH_REST;
            end
            default: begin
                d.phase = PH_REST;
            end
        endcase
        // Partial byte from the last frame is skipped
        eff_pos = (q.cnt == 5'h00) ? round_byte(q.rd_pos) : q.rd_pos;
        avail = (q.res_s2 != q.ack_tgl);
        d.dout = 1'b0;
        d.rd_pos = eff_pos;
        if (eff_pos == 5'(WORD_BITS)) begin
            // Entry finished by rounding; release it
            d.rd_pos = 5'h00;
            d.ack_tgl = ~q.ack_tgl;
        end else if (avail) begin
            d.dout = res_word[4'(WORD_BITS - 1) - eff_pos[3:0]];
            d.rd_pos = eff_pos + 5'h01;
            if (eff_pos == 5'(WORD_BITS - 1)) begin
                d.rd_pos = 5'h00;
                d.ack_tgl = ~q.ack_tgl;
            end
        end
    end

    // Falling-edge register; cs high clears only the frame part
    always_ff @(negedge sclk or posedge cs_n or posedge srst) begin
        if (srst) begin
            q <= '0;
        end else if (cs_n) begin
            q.phase <= PH_CMD;
            q.cnt <= 5'h00;
            q.cmd <= 8'h00;
            q.shift <= 16'h0000;
            q.dout <= 1'b0;
            q.dout_oe <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign dout_q = q.dout;
    assign dout_oe_q = q.dout_oe;
    assign word_q = q.word;
    assign word_tgl_q = q.word_tgl;
    assign ack_tgl_q = q.ack_tgl;

    // Word toggles exactly on the sixteenth word bit
    // Checked at that edge itself: cs usually rises before another one comes
    word_commit_a: assert property (@(negedge sclk) disable iff (srst || cs_n)
        (q.phase == PH_WORD && q.cnt == 5'(WORD_LAST_EDGE))
        |-> (d.word_tgl != q.word_tgl && d.word == shift_next))
        else $error("word not committed on last bit");

endmodule : dacsd_link

// *** design/dacsd_decoder.sv ***
`timescale 1ns/1ps

module dacsd_decoder
    import dacsd_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,
    parameter int CODE_W = DATA_BITS
) (
    // System clock and control
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_q,
    output logic dout_oe_q,
    // Hardware load pin, active low
    input wire logic load_outputs_strobe_n,
    // Conversion results in
    input wire logic res_valid,
    input wire logic [CODE_W-1:0] res_code,
    input wire logic res_twos,
    output logic res_ready_q,
    // Channel state out
    output logic [CHANNELS-1:0][CODE_W-1:0] input_value_q,
    output logic [CHANNELS-1:0][CODE_W-1:0] dac_value_q,
    output dacsd_pwr_type [CHANNELS-1:0] pwr_state_q
);

    // Decode is fixed to the eight-channel, twelve-bit word layout
    if (CHANNELS != NUM_CH || CODE_W != DATA_BITS) begin : g_check
        $error("dacsd_decoder supports only 8 channels of 12 bits");
    end

    // Whole core state
    typedef struct packed {
        logic w_s1;                             // Word toggle sync, first stage
        logic w_s2;                             // Word toggle sync, second stage
        logic w_s3;                             // Word toggle, edge reference
        logic a_s1;                             // Ack toggle sync, first stage
        logic a_s2;                             // Ack toggle sync, second stage
        logic l_s1;                             // Load pin sync, first stage
        logic l_s2;                             // Load pin sync, second stage
        logic l_s3;                             // Load pin, edge reference
        logic [NUM_CH-1:0][DATA_BITS-1:0] inreg;  // Input registers
        logic [NUM_CH-1:0][DATA_BITS-1:0] dacreg; // DAC registers
        dacsd_pwr_type [NUM_CH-1:0] pwr;        // Output buffer states
        logic [WORD_BITS-1:0] res_word;         // Entry offered to the link
        logic res_tgl;                          // Flips per offered entry
        logic res_ready;                        // Room for a new result
    } dacsd_core_type;

    dacsd_core_type q, d;

    // Link-side wires
    logic [WORD_BITS-1:0] link_word;
    logic link_tgl;
    logic link_ack;

    // Serial side runs on its own clock
    dacsd_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout_q(dout_q),
        .dout_oe_q(dout_oe_q),
        .srst(srst),
        .word_q(link_word),
        .word_tgl_q(link_tgl),
        .res_word(q.res_word),
        .res_tgl(q.res_tgl),
        .ack_tgl_q(link_ack)
    );

    // Is channel ch written by a write-through code
    function automatic logic wt_hit(input logic [3:0] code, input int ch);
        unique case (code)
            CTRL_WT_LOW: return ch < NUM_CH / 2;
            CTRL_WT_HIGH: return ch >= NUM_CH / 2;
            default: return 1'b1;
        endcase
    endfunction : wt_hit

    // Map power field to state; bit 3 of result flags a legal code
    function automatic logic [3:0] pwr_decode(input logic [2:0] m);
        unique case (m)
            PM_UP: return {1'b1, PWR_ON};
            PM_HIZ: return {1'b1, PWR_HIZ};
            PM_GND_1K: return {1'b1, PWR_GND_1K};
            PM_GND_100K: return {1'b1, PWR_GND_100K};
            PM_REF_100K: return {1'b1, PWR_REF_100K};
            default: return 4'h0;
        endcase
    endfunction : pwr_decode

    // Offset-binary code to output word
    function automatic logic [WORD_BITS-1:0] fmt_result(input logic [DATA_BITS-1:0] c,
                                                        input logic twos);
        return {LEAD_ZEROS'(0), twos ? {~c[DATA_BITS-1], c[DATA_BITS-2:0]} : c};
    endfunction : fmt_result

    logic new_word;
    logic load_fall;
    logic [3:0] ctrl;
    logic [DATA_BITS-1:0] data;
    logic [3:0] pmode;

    // Only the synchronised toggle qualifies the word bus
    assign new_word = q.w_s2 ^ q.w_s3;
    assign load_fall = q.l_s3 & ~q.l_s2;
    assign ctrl = link_word[CTRL_MSB:CTRL_LSB];
    assign data = link_word[DATA_BITS-1:0];
    assign pmode = pwr_decode(data[PMODE_MSB:PMODE_LSB]);

    // Next-state logic
    always_comb begin
        d = q;
        d.w_s1 = link_tgl;
        d.w_s2 = q.w_s1;
        d.w_s3 = q.w_s2;
        d.a_s1 = link_ack;
        d.a_s2 = q.a_s1;
        d.l_s1 = load_outputs_strobe_n;
        d.l_s2 = q.l_s1;
        d.l_s3 = q.l_s2;
        // Pin load first, so a word in the same cycle has the last say
        if (load_fall) begin
            d.dacreg = q.inreg;
        end
        if (new_word) begin
            unique case (ctrl) inside
                CTRL_NOP: begin
                    d.inreg = d.inreg;
                end
                CTRL_RESET: begin
                    // Mixed preset bits are taken as no action
                    if (data[PRESET_BIT_A] == data[PRESET_BIT_B]) begin
                        for (int ch = 0; ch < NUM_CH; ch++) begin
                            d.inreg[ch] = data[PRESET_BIT_A] ? PRESET_VAL : CLEAR_VAL;
                            d.dacreg[ch] = data[PRESET_BIT_A] ? PRESET_VAL : CLEAR_VAL;
                        end
                    end
                end
                [CTRL_LOAD_FIRST:CTRL_LOAD_LAST]: begin
                    d.inreg[3'(ctrl - CTRL_LOAD_FIRST)] = data;
                end
                CTRL_WT_LOW, CTRL_WT_HIGH, CTRL_WT_ALL: begin
                    for (int ch = 0; ch < NUM_CH; ch++) begin
                        if (wt_hit(ctrl, ch)) begin
                            d.inreg[ch] = data;
                            d.dacreg[ch] = data;
                        end
                    end
                end
                CTRL_IN_ALL: begin
                    for (int ch = 0; ch < NUM_CH; ch++) begin
                        d.inreg[ch] = data;
                    end
                end
                CTRL_XFER: begin
                    for (int ch = 0; ch < NUM_CH; ch++) begin
                        if (data[MASK_LSB + ch]) begin
                            d.dacreg[ch] = q.inreg[ch];
                        end
                    end
                end
                CTRL_POWER: begin
                    // Unlisted mode codes leave every channel alone
                    for (int ch = 0; ch < NUM_CH; ch++) begin
                        if (data[MASK_LSB + ch] && pmode[3]) begin
                            d.pwr[ch] = dacsd_pwr_type'(pmode[2:0]);
                        end
                    end
                end
            endcase
        end
        // Single-entry hand-off to the link
        if (q.res_ready && res_valid) begin
            d.res_word = fmt_result(res_code, res_twos);
            d.res_tgl = ~q.res_tgl;
        end
        d.res_ready = (d.res_tgl == d.a_s2);
    end

    // State register; synchronous reset, updates on every clock with clk_en high
    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                q.pwr[ch] <= RESET_PWR;
            end
            q.l_s1 <= 1'b1;
            q.l_s2 <= 1'b1;
            q.l_s3 <= 1'b1;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign input_value_q = q.inreg;
    assign dac_value_q = q.dacreg;
    assign pwr_state_q = q.pwr;
    assign res_ready_q = q.res_ready;

    logic fire;
    assign fire = clk_en && new_word && !load_fall;

    nop_idle_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_NOP)
        |=> ($stable(q.inreg) && $stable(q.dacreg) && $stable(q.pwr)))
        else $error("nop changed channel state");

    clear_all_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_RESET && !data[11] && !data[9])
        |=> (q.dacreg == '0 && q.inreg == '0 && $stable(q.pwr)))
        else $error("reset code did not clear");

    preset_all_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_RESET && data[11] && data[9])
        |=> (q.dacreg == '1 && $stable(q.pwr)))
        else $error("preset code did not fill ones");

    load_one_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == 4'h9)
        |=> (q.inreg[7] == $past(data) && $stable(q.dacreg)))
        else $error("channel 7 input load wrong");

    wt_low_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_WT_LOW)
        |=> (q.dacreg[3] == $past(data) && $stable(q.dacreg[4])))
        else $error("low-half write-through wrong");

    wt_high_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_WT_HIGH)
        |=> (q.dacreg[4] == $past(data) && $stable(q.dacreg[3])))
        else $error("high-half write-through wrong");

    wt_all_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_WT_ALL)
        |=> (q.dacreg[0] == $past(data) && q.inreg[7] == $past(data)))
        else $error("all-channel write-through wrong");

    in_all_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_IN_ALL)
        |=> (q.inreg[0] == $past(data) && $stable(q.dacreg)))
        else $error("input-only load touched outputs");

    xfer_mask_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_XFER)
        |=> (q.dacreg[0] == ($past(data[4]) ? $past(q.inreg[0]) : $past(q.dacreg[0]))))
        else $error("masked transfer wrong on channel 0");

    power_up_a: assert property (@(posedge clock) disable iff (srst)
        (fire && ctrl == CTRL_POWER && data[3:1] == PM_UP && data[11])
        |=> (q.pwr[7] == PWR_ON))
        else $error("masked power-up missed");

    lead_zero_a: assert property (@(posedge clock) disable iff (srst)
        (!q.res_ready) |-> (q.res_word[15:12] == 4'h0))
        else $error("result leading bits not zero");

    twos_fmt_a: assert property (@(posedge clock) disable iff (srst)
        (clk_en && q.res_ready && res_valid)
        |=> (q.res_word[11] == ($past(res_twos) ^ $past(res_code[11]))) ##1 !q.res_ready)
        else $error("result coding wrong");

endmodule : dacsd_decoder

// *** dv/dacsd_host_model.sv ***
`timescale 1ns/1ps

module dacsd_host_model (
    // Serial pins towards the device
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_q,
    input wire logic dout_oe_q
);
    // Bits seen on data-out, newest at bit 0
    logic [23:0] rx_q;

    // Idle: clock parked high, no frame
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        rx_q = '0;
    end

    // One frame of n falling edges; command byte then word, MSB first
    task automatic frame(input logic [23:0] bits, input int n);
        rx_q = '0;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = bits[23 - (i % 24)];
            #7.5;
            sclk = 1'b0;
            #7.5;
            // Undriven data-out reads as low here
            rx_q = {rx_q[22:0], dout_oe_q ? dout_q : 1'b0};
            sclk = 1'b1;
        end
        #7.5;
        cs_n = 1'b1;
        // Released line must not keep its last value
        din = ~din;
        // Device takes one word per frame, so space frames out
        #500;
    endtask : frame
endmodule : dacsd_host_model

// *** dv/dac_serial_command_decoder_test.sv ***
`timescale 1ns/1ps

module dac_serial_command_decoder_test;
    import dacsd_pkg::*;

    // Clock, reset and device inputs
    logic clock;
    logic srst;
    logic clk_en;
    logic load_outputs_strobe_n;
    logic res_valid;
    logic [DATA_BITS-1:0] res_code;
    logic res_twos;
    // Serial pins
    wire sclk;
    wire cs_n;
    wire din;
    wire dout_q;
    wire dout_oe_q;
    // Device outputs
    logic res_ready_q;
    logic [NUM_CH-1:0][DATA_BITS-1:0] input_value_q;
    logic [NUM_CH-1:0][DATA_BITS-1:0] dac_value_q;
    dacsd_pwr_type [NUM_CH-1:0] pwr_state_q;
    // Expected channel state
    logic [NUM_CH-1:0][DATA_BITS-1:0] exp_in;
    logic [NUM_CH-1:0][DATA_BITS-1:0] exp_dac;
    dacsd_pwr_type [NUM_CH-1:0] exp_pw;
    int err_count;
    int compares;

    dacsd_decoder i_dut (
        .clock(clock),
        .srst(srst),
        .clk_en(clk_en),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout_q(dout_q),
        .dout_oe_q(dout_oe_q),
        .load_outputs_strobe_n(load_outputs_strobe_n),
        .res_valid(res_valid),
        .res_code(res_code),
        .res_twos(res_twos),
        .res_ready_q(res_ready_q),
        .input_value_q(input_value_q),
        .dac_value_q(dac_value_q),
        .pwr_state_q(pwr_state_q)
    );

    dacsd_host_model i_host (
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout_q(dout_q),
        .dout_oe_q(dout_oe_q)
    );

    // System clock, 100 ns
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Compare one result
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // All channel registers against the expectation
    task automatic chk_state();
        chk(input_value_q, exp_in);
        chk(dac_value_q, exp_dac);
        chk(pwr_state_q, exp_pw);
    endtask : chk_state

    // DAC word, n edges; wait covers sync and frame spacing
    task automatic send(input logic [15:0] word, input int n);
        i_host.frame({SELECT_NIBBLE, 4'h0, word}, n);
        repeat (8) @(posedge clock);
    endtask : send

    // Hand one result to the device
    task automatic offer(input logic [11:0] code, input logic twos);
        for (int k = 0; k < 50; k++) begin
            @(negedge clock);
            if (res_ready_q === 1'b1) break;
        end
        @(posedge clock);
        res_valid <= 1'b1;
        res_code <= code;
        res_twos <= twos;
        @(posedge clock);
        res_valid <= 1'b0;
        // Entry taken; no room until the link has read it
        @(negedge clock);
        chk(res_ready_q, 1'b0);
        // Frame only once the entry is handed over
        i_host.frame(24'h0, 2);
    endtask : offer

    function automatic dacsd_pwr_type pw_of(input logic [2:0] pm);
        case (pm)
            PM_UP: return PWR_ON;
            PM_HIZ: return PWR_HIZ;
            PM_GND_1K: return PWR_GND_1K;
            PM_REF_100K: return PWR_REF_100K;
            default: return PWR_GND_100K;
        endcase
    endfunction : pw_of

    // Single-channel loads leave outputs alone
    task automatic t_load();
        logic [11:0] v;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            v = 12'(ch * 12'h123 + 12'h005);
            send({4'(CTRL_LOAD_FIRST + ch), v}, 24);
            exp_in[ch] = v;
            chk_state();
        end
    endtask : t_load

    // Masked copy of inputs to outputs
    task automatic t_xfer();
        send({CTRL_XFER, 8'ha5, 4'h0}, 24);
        for (int ch = 0; ch < NUM_CH; ch++) if (ch % 2 == ((ch < 4) ? 0 : 1)) exp_dac[ch] = exp_in[ch];
        chk_state();
    endtask : t_xfer

    // Write-through low, high, all; then inputs only
    task automatic t_write();
        logic hit;
        for (int i = 0; i < 4; i++) begin
            send({4'(CTRL_WT_LOW + i), 12'(12'h3c0 + i)}, 24);
            for (int ch = 0; ch < NUM_CH; ch++) begin
                hit = (i == 0) ? (ch < 4) : (i == 1) ? (ch >= 4) : 1'b1;
                if (hit) exp_in[ch] = 12'(12'h3c0 + i);
                if (hit && i < 3) exp_dac[ch] = 12'(12'h3c0 + i);
            end
            chk_state();
        end
        // Load pin copies every input register
        @(posedge clock);
        load_outputs_strobe_n <= 1'b0;
        @(posedge clock);
        load_outputs_strobe_n <= 1'b1;
        repeat (6) @(posedge clock);
        exp_dac = exp_in;
        chk_state();
    endtask : t_write

    // Words that must change nothing; the last one lands once clk_en returns
    task automatic t_refused();
        send({CTRL_NOP, 12'hfff}, 24);
        chk_state();
        send({CTRL_RESET, 12'h200}, 24);
        chk_state();
        send({CTRL_POWER, 8'hff, 3'h3, 1'b0}, 24);
        chk_state();
        // Command byte that does not select the decoder
        i_host.frame({4'h2, 4'h0, CTRL_WT_ALL, 12'h0ab}, 24);
        repeat (8) @(posedge clock);
        chk_state();
        send({CTRL_LOAD_FIRST, 12'h0ab}, 20);
        chk_state();
        send({CTRL_WT_ALL, 12'h0ab}, 5);
        chk_state();
        // Word sent while frozen lands once enabled again
        @(posedge clock);
        clk_en <= 1'b0;
        send({CTRL_WT_ALL, 12'h0ab}, 24);
        chk_state();
        clk_en <= 1'b1;
        repeat (4) @(posedge clock);
        exp_in = {NUM_CH{12'h0ab}};
        exp_dac = {NUM_CH{12'h0ab}};
        chk_state();
    endtask : t_refused

    // Every power mode under a moving mask
    task automatic t_power();
        logic [2:0] pm [5] = '{PM_HIZ, PM_GND_1K, PM_REF_100K, PM_UP, PM_GND_100K};
        logic [7:0] m;
        for (int i = 0; i < 5; i++) begin
            m = 8'(8'h1b << i);
            send({CTRL_POWER, m, pm[i], 1'b0}, 24);
            for (int ch = 0; ch < NUM_CH; ch++) if (m[ch]) exp_pw[ch] = pw_of(pm[i]);
            chk_state();
        end
    endtask : t_power

    // Preset then clear; power states stay
    task automatic t_clear();
        send({CTRL_RESET, 12'hfff}, 24);
        exp_in = '1;
        exp_dac = '1;
        chk_state();
        send({CTRL_RESET, 12'h5ff}, 24);
        exp_in = '0;
        exp_dac = '0;
        chk_state();
    endtask : t_clear

    // Full, partial-first and partial-second reads
    task automatic t_result();
        offer(12'h8f3, 1'b0);
        i_host.frame(24'h0, 16);
        chk(i_host.rx_q[15:0], 16'h08f3);
        offer(12'h8f3, 1'b1);
        i_host.frame(24'h0, 16);
        chk(i_host.rx_q[15:0], 16'h00f3);
        offer(12'h9c3, 1'b0);
        i_host.frame(24'h0, 4);
        i_host.frame(24'h0, 8);
        chk(i_host.rx_q[7:0], 8'hc3);
        offer(12'h5a6, 1'b0);
        i_host.frame(24'h0, 12);
        i_host.frame(24'h0, 16);
        chk(i_host.rx_q[15:0], 16'h0000);
        offer(12'h7e1, 1'b0);
        i_host.frame(24'h0, 16);
        chk(i_host.rx_q[15:0], 16'h07e1);
    endtask : t_result

    // Counts, verdict, stop
    task automatic end_of_test();
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        err_count = 0;
        compares = 0;
        clk_en = 1'b1;
        load_outputs_strobe_n = 1'b1;
        res_valid = 1'b0;
        res_code = '0;
        res_twos = 1'b0;
        srst = 1'b1;
        exp_in = '0;
        exp_dac = '0;
        for (int ch = 0; ch < NUM_CH; ch++) exp_pw[ch] = RESET_PWR;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        chk_state();
        t_load();
        t_xfer();
        t_write();
        t_refused();
        t_power();
        t_clear();
        t_result();
        end_of_test();
    end

    // Watchdog, well past the expected run
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule : dac_serial_command_decoder_test
